// ### hw/odtpd_core.sv
// termination response classifier around precharge power-down entry and exit
// How it works
// - transition handling only applies when power-down keeps the dll off.
// - entry window spans anticipation interval before first cke low edge.
// - refresh in progress extends entry window to refresh cycle end.
// - exit window spans anticipation before cke high plus dll exit delay.
// - anticipation interval is write latency minus one cycles.
// - turn-on and turn-off latency are write latency minus two.
// - turn-on inside window ranges from lesser minimum to greater maximum.
// - turn-off inside window ranges from lesser minimum to greater maximum.
// - exit: before window async, after window sync, inside either.
// - short cke low pulse: either from entry start to exit end.
// - short cke high pulse: either from exit start to entry end.
`default_nettype none

module odtpd_core
   import odtpd_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   input  wire logic        ck_in,
   input  wire logic        cke_in,
   input  wire logic        odt_in,
   input  wire logic        refresh_in,
   input  wire logic        pd_dll_keep_in,
   input  wire logic [3:0]  cwl_in,
   input  wire logic [3:0]  al_in,
   output logic             window_out,
   output logic             async_only_out,
   output logic             event_out,
   output logic             event_rise_out,
   output logic [1:0]       event_class_out,
   output logic [23:0]      early_ps_out,
   output logic [23:0]      late_ps_out
);
   logic                  lr1, lrst, dk1, dk2;
   logic [HIST_DEPTH-1:0] h_cke, h_odt, h_ref;
   logic [HIST_DEPTH-1:0] next_h_cke, next_h_odt, next_h_ref;
   logic [5:0]            fall_age, rise_age, next_fall_age, next_rise_age;
   odtpd_state_t          st, next_st;
   logic [7:0]            rfc_cnt, next_rfc_cnt, xp_cnt, next_xp_cnt;
   logic                  rfc_pd, next_rfc_pd;
   odtpd_status_t         stat, next_stat, cdc_stat;
   logic                  cdc_upd;
   logic [4:0]            wl, tanpd, odtl;
   logic                  dll_off, d_cke, d_pcke, d_odt, d_podt, d_ref;
   logic                  d_fall, d_rise, fall_ahead, rise_ahead, win, ev;
   logic [23:0]           on_min, on_max, off_min, off_max;
   odtpd_class_t          cls;

   // link reset: level crossing into the ck domain
   // the mode bit comes from the system side, so it crosses like the reset does
   always_ff @(posedge ck_in) begin
      lr1  <= reset_in;
      lrst <= lr1;
      dk1  <= pd_dll_keep_in;
      dk2  <= dk1;
   end

   always_comb begin
      wl    = 5'(cwl_in) + 5'(al_in);
      tanpd = (wl > 5'd1) ? wl - 5'd1 : 5'd0;
      odtl  = (wl > 5'd2) ? wl - 5'd2 : 5'd0;
      dll_off = ~dk2;
      // responses are judged tanpd cycles late, once the cke future is known
      d_cke  = h_cke[tanpd];
      d_pcke = h_cke[tanpd + 5'd1];
      d_odt  = h_odt[tanpd];
      d_podt = h_odt[tanpd + 5'd1];
      d_ref  = h_ref[tanpd];
      d_fall = d_pcke & ~d_cke;
      d_rise = ~d_pcke & d_cke;
      fall_ahead = {1'b0, tanpd} > fall_age;
      rise_ahead = {1'b0, tanpd} > rise_age;
   end

   always_comb begin
      next_h_cke    = {h_cke[HIST_DEPTH-2:0], cke_in};
      next_h_odt    = {h_odt[HIST_DEPTH-2:0], odt_in};
      next_h_ref    = {h_ref[HIST_DEPTH-2:0], refresh_in};
      next_fall_age = (h_cke[0] & ~cke_in) ? 6'h00 : (fall_age == AGE_SAT) ? AGE_SAT : fall_age + 6'h01;
      next_rise_age = (~h_cke[0] & cke_in) ? 6'h00 : (rise_age == AGE_SAT) ? AGE_SAT : rise_age + 6'h01;
   end

   always_comb begin
      next_st      = st;
      next_xp_cnt  = (xp_cnt != 8'h00) ? xp_cnt - 8'h01 : 8'h00;
      next_rfc_cnt = (rfc_cnt != 8'h00) ? rfc_cnt - 8'h01 : 8'h00;
      next_rfc_pd  = rfc_pd & (rfc_cnt > 8'h01);
      if (d_ref) begin
         next_rfc_cnt = TRFC_CYC;
      end
      if (d_fall && rfc_cnt > 8'h01) begin
         next_rfc_pd = 1'b1;
      end
      unique case (st)
         ST_ON: begin
            if (d_fall) begin
               next_st = ST_PD;
            end
         end
         ST_PD: begin
            if (d_rise) begin
               next_st     = ST_EXIT;
               next_xp_cnt = TXPDLL_CYC;
            end
         end
         ST_EXIT: begin
            if (d_fall) begin
               next_st = ST_PD;
            end else if (xp_cnt <= 8'h01) begin
               next_st = ST_ON;
            end
         end
         default: next_st = ST_ON;
      endcase
   end

   always_comb begin
      // the cke edge itself still belongs to its window, else short pulses slip through
      win = dll_off & ((st == ST_ON & (fall_ahead | d_fall))
                     | (st == ST_PD & (rise_ahead | d_rise))
                     | (st == ST_EXIT)
                     | rfc_pd);
      ev  = d_odt ^ d_podt;
      if (win) begin
         cls = CLS_EITHER;
      end else if (dll_off && st == ST_PD) begin
         cls = CLS_ASYNC;
      end else begin
         cls = CLS_SYNC;
      end
      on_min  = 24'(odtl) * TCK_PS + TAON_MIN_PS;
      on_max  = 24'(odtl) * TCK_PS + TAON_MAX_PS;
      off_min = 24'(odtl) * TCK_PS + TAOF_MIN_PS;
      off_max = 24'(odtl) * TCK_PS + TAOF_MAX_PS;
      next_stat            = stat;
      next_stat.window     = win;
      next_stat.async_only = (cls == CLS_ASYNC);
      next_stat.ev         = ev;
      if (ev) begin
         next_stat.ev_rise = d_odt;
         next_stat.cls     = cls;
         unique case (cls)
            CLS_SYNC: begin
               next_stat.early_ps = d_odt ? on_min : off_min;
               next_stat.late_ps  = d_odt ? on_max : off_max;
            end
            CLS_ASYNC: begin
               next_stat.early_ps = d_odt ? TAONPD_MIN_PS : TAOFPD_MIN_PS;
               next_stat.late_ps  = d_odt ? TAONPD_MAX_PS : TAOFPD_MAX_PS;
            end
            default: begin
               if (d_odt) begin
                  next_stat.early_ps = (on_min < TAONPD_MIN_PS) ? on_min : TAONPD_MIN_PS;
                  next_stat.late_ps  = (on_max > TAONPD_MAX_PS) ? on_max : TAONPD_MAX_PS;
               end else begin
                  next_stat.early_ps = (off_min < TAOFPD_MIN_PS) ? off_min : TAOFPD_MIN_PS;
                  next_stat.late_ps  = (off_max > TAOFPD_MAX_PS) ? off_max : TAOFPD_MAX_PS;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ck_in) begin
      if (lrst) begin
         h_cke    <= '1;
         h_odt    <= '0;
         h_ref    <= '0;
         fall_age <= AGE_SAT;
         rise_age <= AGE_SAT;
         st       <= ST_ON;
         rfc_cnt  <= 8'h00;
         xp_cnt   <= 8'h00;
         rfc_pd   <= 1'b0;
         stat     <= '0;
      end else begin
         h_cke    <= next_h_cke;
         h_odt    <= next_h_odt;
         h_ref    <= next_h_ref;
         fall_age <= next_fall_age;
         rise_age <= next_rise_age;
         st       <= next_st;
         rfc_cnt  <= next_rfc_cnt;
         xp_cnt   <= next_xp_cnt;
         rfc_pd   <= next_rfc_pd;
         stat     <= next_stat;
      end
   end

   odtpd_xfer #(
      .W($bits(odtpd_status_t))
   ) u_xfer (
      .src_clk_in     (ck_in),
      .src_reset_in   (lrst),
      .src_data_in    (stat),
      .dst_clk_in     (clk_in),
      .dst_reset_in   (reset_in),
      .dst_data_out   (cdc_stat),
      .dst_update_out (cdc_upd)
   );

   // event pulse lasts one system cycle per link cycle that carried a change
   always_comb begin
      window_out      = cdc_stat.window;
      async_only_out  = cdc_stat.async_only;
      event_out       = cdc_upd & cdc_stat.ev;
      event_rise_out  = cdc_stat.ev_rise;
      event_class_out = cdc_stat.cls;
      early_ps_out    = cdc_stat.early_ps;
      late_ps_out     = cdc_stat.late_ps;
   end

   chk_dll_on_sync: assert property (@(posedge ck_in) disable iff (lrst)
      !dll_off |=> !stat.window && !stat.async_only && (!stat.ev || stat.cls == CLS_SYNC))
      else $error("window open while dll kept on");
   chk_entry_edge: assert property (@(posedge ck_in) disable iff (lrst)
      st == ST_ON && d_fall |=> st == ST_PD)
      else $error("entry edge did not reach power-down");
   chk_refresh_ext: assert property (@(posedge ck_in) disable iff (lrst)
      dll_off && rfc_pd && st == ST_PD |-> win)
      else $error("refresh extension not in window");
   chk_exit_open: assert property (@(posedge ck_in) disable iff (lrst)
      dll_off && st == ST_PD && d_rise |=> st == ST_EXIT && win)
      else $error("exit window not opened");
   chk_anpd_ahead: assert property (@(posedge ck_in) disable iff (lrst)
      dll_off && st == ST_ON && {1'b0, tanpd} > fall_age |-> win)
      else $error("anticipation interval missed");
   chk_turnon_range: assert property (@(posedge ck_in) disable iff (lrst)
      ev && cls == CLS_EITHER && d_odt |=> stat.early_ps <= TAONPD_MIN_PS && stat.late_ps >= TAONPD_MAX_PS)
      else $error("turn-on range too narrow");
   chk_turnoff_async: assert property (@(posedge ck_in) disable iff (lrst)
      ev && cls == CLS_ASYNC && !d_odt |=> stat.early_ps == TAOFPD_MIN_PS && stat.late_ps == TAOFPD_MAX_PS)
      else $error("async turn-off bounds wrong");
   chk_after_exit: assert property (@(posedge ck_in) disable iff (lrst)
      ev && st == ST_ON && !win |=> stat.ev && stat.cls == CLS_SYNC && stat.early_ps == $past(on_min) | !stat.ev_rise)
      else $error("response after exit not synchronous");
   sequence s_fall_judged;
      dll_off && st == ST_ON && d_fall;
   endsequence

   sequence s_rise_next;
      dll_off && d_rise;
   endsequence

   chk_short_low: assert property (@(posedge ck_in) disable iff (lrst)
      s_fall_judged ##1 s_rise_next |-> win && st == ST_PD)
      else $error("overlap of entry and exit not covered");
   chk_short_high: assert property (@(posedge ck_in) disable iff (lrst)
      dll_off && st == ST_EXIT && d_fall |=> st == ST_PD)
      else $error("short high pulse lost re-entry");
   chk_event_pulse: assert property (@(posedge clk_in) disable iff (reset_in) event_out |=> !event_out)
      else $error("event pulse longer than one cycle");
endmodule

`default_nettype wire

// ### hw/odtpd_pkg.sv
// package with timing constants and carrier types, plus the clock crossing leaf
`default_nettype none

package odtpd_pkg;
   // link clock period as seen by the device (tCK)
   localparam int unsigned CK_PERIOD_PS   = 80000;
   localparam int unsigned TRFC_NS        = 160;
   localparam int unsigned TXPDLL_NS      = 24;
   localparam int unsigned TRFC_CYC_I     = (TRFC_NS * 1000 + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
   localparam int unsigned TXPDLL_CYC_I   = (TXPDLL_NS * 1000 + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
   localparam logic [7:0]  TRFC_CYC       = 8'((TRFC_CYC_I < 1) ? 1 : TRFC_CYC_I);
   localparam logic [7:0]  TXPDLL_CYC     = 8'((TXPDLL_CYC_I < 1) ? 1 : TXPDLL_CYC_I);
   // asynchronous power-down turn-on/off delays
   localparam logic [23:0] TAONPD_MIN_PS  = 24'd2000;
   localparam logic [23:0] TAONPD_MAX_PS  = 24'd8500;
   localparam logic [23:0] TAOFPD_MIN_PS  = 24'd2000;
   localparam logic [23:0] TAOFPD_MAX_PS  = 24'd8500;
   // synchronous turn-on skew, plain defaults
   localparam logic [23:0] TAON_MIN_PS    = 24'd0;
   localparam logic [23:0] TAON_MAX_PS    = 24'd400;
   // turn-off skew 0.5 tCK +/- 0.2 tCK
   localparam logic [23:0] TAOF_MIN_PS    = 24'(CK_PERIOD_PS * 3 / 10);
   localparam logic [23:0] TAOF_MAX_PS    = 24'(CK_PERIOD_PS * 7 / 10);
   localparam logic [23:0] TCK_PS         = 24'(CK_PERIOD_PS);
   localparam int unsigned HIST_DEPTH     = 33;
   localparam logic [5:0]  AGE_SAT        = 6'h3f;

   typedef enum logic [2:0] {
      ST_ON   = 3'h1,
      ST_PD   = 3'h2,
      ST_EXIT = 3'h4
   } odtpd_state_t;

   typedef enum logic [1:0] {
      CLS_SYNC   = 2'h0,
      CLS_ASYNC  = 2'h1,
      CLS_EITHER = 2'h2
   } odtpd_class_t;

   typedef struct packed {
      logic         window;
      logic         async_only;
      logic         ev;
      logic         ev_rise;
      odtpd_class_t cls;
      logic [23:0]  early_ps;
      logic [23:0]  late_ps;
   } odtpd_status_t;
endpackage

// word crossing: toggle per source cycle, data held a full source period
module odtpd_xfer #(
   parameter int W = 8
) (
   input  wire logic         src_clk_in,
   input  wire logic         src_reset_in,
   input  wire logic [W-1:0] src_data_in,
   input  wire logic         dst_clk_in,
   input  wire logic         dst_reset_in,
   output logic [W-1:0]      dst_data_out,
   output logic              dst_update_out
);
   logic [W-1:0] hold;
   logic         tog;
   logic         s1, s2, s3;
   logic [W-1:0] next_hold;
   logic         next_tog;

   always_comb begin
      next_hold = src_data_in;
      next_tog  = ~tog;
   end

   always_ff @(posedge src_clk_in) begin
      if (src_reset_in) begin
         hold <= '0;
         tog  <= 1'b0;
      end else begin
         hold <= next_hold;
         tog  <= next_tog;
      end
   end

   // hold is stable for one whole source period, far longer than the sync delay
   always_ff @(posedge dst_clk_in) begin
      if (dst_reset_in) begin
         s1             <= 1'b0;
         s2             <= 1'b0;
         s3             <= 1'b0;
         dst_data_out   <= '0;
         dst_update_out <= 1'b0;
      end else begin
         s1             <= tog;
         s2             <= s1;
         s3             <= s2;
         dst_update_out <= s2 ^ s3;
         if (s2 ^ s3) begin
            dst_data_out <= hold;
         end
      end
   end
endmodule

`default_nettype wire

// ### hw/odtpd_note_placeholder.sv
// intentionally empty companion file kept out of the build
`default_nettype none
`default_nettype wire

// ### tb/odtpd_ctrl_model.sv
// controller-side model: link clock, clock enable, termination strobe and refresh
`default_nettype none

module odtpd_ctrl_model (
   output logic ck_out,
   output logic cke_out,
   output logic odt_out,
   output logic refresh_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // runs free like a real controller clock; the offset keeps it unrelated to clk_in
   initial begin
      ck_out = 1'b0;
      #13;
      forever #40 ck_out = ~ck_out;
   end

   initial begin
      cke_out     = 1'b1;
      odt_out     = 1'b0;
      refresh_out = 1'b0;
   end

   // levels change on the falling edge, half a cycle clear of sampling, then hold n cycles
   task automatic run(input logic cke_v, input logic odt_v, input int n);
      @(negedge ck_out);
      cke_out = cke_v;
      odt_out = odt_v;
      repeat (n) @(posedge ck_out);
   endtask

   // one-cycle refresh command, then cke set on the very next cycle
   task automatic refresh_cmd(input logic cke_v, input int n);
      @(negedge ck_out);
      refresh_out = 1'b1;
      @(negedge ck_out);
      refresh_out = 1'b0;
      cke_out     = cke_v;
      repeat (n) @(posedge ck_out);
   endtask
endmodule

`default_nettype wire

// ### tb/test_odt_powerdown_mode_transition.sv
// self-checking bench for the termination response classifier
`default_nettype none

module test_odt_powerdown_mode_transition;
   import odtpd_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [3:0]  CWL    = 4'h5;
   localparam logic [3:0]  AL     = 4'h0;
   localparam logic [23:0] LAT_PS = 24'((int'(CWL) + int'(AL) - 2) * int'(TCK_PS));
   localparam int          LIMIT  = 20000;

   logic        clk_in;
   logic        reset_in;
   logic        pd_dll_keep_in;
   wire logic   ck;
   wire logic   cke;
   wire logic   odt;
   wire logic   refresh;
   logic        window;
   logic        async_only;
   logic        ev;
   logic        ev_rise;
   logic [1:0]  ev_cls;
   logic [23:0] early;
   logic [23:0] late;
   logic        got;
   logic        c_rise;
   logic [1:0]  c_cls;
   logic [23:0] c_early;
   logic [23:0] c_late;
   int          err_count;
   int          n_checks;
   int          cyc;

   odtpd_ctrl_model odtpd_ctrl_model_inst (.ck_out(ck), .cke_out(cke), .odt_out(odt), .refresh_out(refresh));

   odtpd_core odtpd_core_inst (
      .clk_in(clk_in), .reset_in(reset_in), .ck_in(ck), .cke_in(cke), .odt_in(odt),
      .refresh_in(refresh), .pd_dll_keep_in(pd_dll_keep_in), .cwl_in(CWL), .al_in(AL),
      .window_out(window), .async_only_out(async_only), .event_out(ev), .event_rise_out(ev_rise),
      .event_class_out(ev_cls), .early_ps_out(early), .late_ps_out(late));

   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   // event outputs are only meaningful in the pulse cycle; sampled mid-cycle, clear of the launch edge
   always @(negedge clk_in) begin
      cyc++;
      if (ev === 1'b1) begin
         got     = 1'b1;
         c_rise  = ev_rise;
         c_cls   = ev_cls;
         c_early = early;
         c_late  = late;
      end
      if (cyc == LIMIT) begin
         err_count++;
         results();
      end
   end

   task automatic results();
      if (err_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic arm();
      got = 1'b0;
   endtask

   task automatic go(input logic cke_v, input logic odt_v, input int n);
      odtpd_ctrl_model_inst.run(cke_v, odt_v, n);
   endtask

   task automatic expect_ev(input logic rise, input logic [1:0] cls);
      logic [23:0] lo;
      logic [23:0] hi;
      logic [23:0] pmin;
      logic [23:0] pmax;
      int          k;
      lo   = LAT_PS + (rise ? TAON_MIN_PS : TAOF_MIN_PS);
      hi   = LAT_PS + (rise ? TAON_MAX_PS : TAOF_MAX_PS);
      pmin = rise ? TAONPD_MIN_PS : TAOFPD_MIN_PS;
      pmax = rise ? TAONPD_MAX_PS : TAOFPD_MAX_PS;
      if (cls == CLS_ASYNC) begin
         lo = pmin;
         hi = pmax;
      end else if (cls == CLS_EITHER) begin
         lo = (pmin < lo) ? pmin : lo;
         hi = (pmax > hi) ? pmax : hi;
      end
      k = 0;
      while (got !== 1'b1 && k < 800) begin
         @(negedge clk_in);
         k++;
      end
      check("event_seen", {23'h0, got}, 24'h1);
      check("event_rise", {23'h0, c_rise}, {23'h0, rise});
      check("event_class", {22'h0, c_cls}, {22'h0, cls});
      check("early_ps", c_early, lo);
      check("late_ps", c_late, hi);
   endtask

   task automatic t_sync();
      arm();
      go(1'b1, 1'b1, 12);
      expect_ev(1'b1, CLS_SYNC);
      arm();
      go(1'b1, 1'b0, 12);
      expect_ev(1'b0, CLS_SYNC);
   endtask

   task automatic t_entry();
      arm();
      go(1'b1, 1'b1, 2);
      go(1'b0, 1'b1, 12);
      expect_ev(1'b1, CLS_EITHER);
      arm();
      go(1'b0, 1'b0, 12);
      expect_ev(1'b0, CLS_ASYNC);
      @(negedge clk_in);
      check("async_only", {23'h0, async_only}, 24'h1);
   endtask

   task automatic t_exit();
      arm();
      go(1'b0, 1'b1, 8);
      go(1'b1, 1'b1, 12);
      expect_ev(1'b1, CLS_ASYNC);
      go(1'b0, 1'b1, 12);
      arm();
      go(1'b0, 1'b0, 2);
      go(1'b1, 1'b0, 12);
      expect_ev(1'b0, CLS_EITHER);
      arm();
      go(1'b1, 1'b1, 12);
      expect_ev(1'b1, CLS_SYNC);
      go(1'b1, 1'b0, 12);
   endtask

   task automatic t_short();
      arm();
      go(1'b0, 1'b1, 1);
      go(1'b1, 1'b1, 12);
      expect_ev(1'b1, CLS_EITHER);
      go(1'b0, 1'b1, 12);
      arm();
      go(1'b1, 1'b0, 1);
      go(1'b0, 1'b0, 12);
      expect_ev(1'b0, CLS_EITHER);
      go(1'b1, 1'b0, 12);
   endtask

   // refresh still running when cke falls stretches the entry window one cycle further
   task automatic t_refresh();
      arm();
      odtpd_ctrl_model_inst.refresh_cmd(1'b0, 1);
      go(1'b0, 1'b1, 12);
      expect_ev(1'b1, CLS_EITHER);
   endtask

   // mode crosses in two link cycles before events count; the long idle covers that with room to spare
   task automatic t_dll_keep();
      @(negedge clk_in);
      pd_dll_keep_in = 1'b1;
      go(1'b1, 1'b0, 40);
      go(1'b0, 1'b0, 12);
      arm();
      go(1'b0, 1'b1, 12);
      expect_ev(1'b1, CLS_SYNC);
      @(negedge clk_in);
      check("window", {23'h0, window}, 24'h0);
   endtask

   initial begin
      reset_in       = 1'b1;
      pd_dll_keep_in = 1'b0;
      got            = 1'b0;
      err_count      = 0;
      n_checks       = 0;
      cyc            = 0;
      repeat (20) @(negedge ck);
      @(negedge clk_in);
      reset_in = 1'b0;
      go(1'b1, 1'b0, 10);
      t_sync();
      t_entry();
      t_exit();
      t_short();
      t_refresh();
      t_dll_keep();
      results();
   end
endmodule

`default_nettype wire
